/* File: hdl/clock_buffer_consts.vh */
`ifndef CLOCK_BUFFER_CONSTS_VH
`define CLOCK_BUFFER_CONSTS_VH

// ****************************************
// Register byte addresses (byte index * 4)
// ****************************************
`define CTRL0_ADDR          8'h00
`define OE_LOW_ADDR         8'h04
`define OE_MID_ADDR         8'h08
`define PLL_OVR_ADDR        8'h48
`define STATUS_ADDR         8'h80

// ****************************************
// Reset values
// ****************************************
`define OE_LOW_RESET        8'hff
`define OE_MID_RESET        8'hff
`define OE_HIGH_RESET       3'h7
`define PLL_OVR_RESET       3'h0

// ****************************************
// Field positions
// ****************************************
`define CTRL0_FREQ_BIT      0
`define CTRL0_OE_LSB        3
`define CTRL0_OE_MSB        5
`define CTRL0_MODE_LSB      6
`define CTRL0_MODE_MSB      7
`define OVR_ENABLE_BIT      2

// ****************************************
// PLL mode readback codes
// ****************************************
`define MODE_LOW_BW         2'h0
`define MODE_BYPASS         2'h1
`define MODE_HIGH_BW        2'h3

// ****************************************
// Tri-level strap codes
// ****************************************
`define TRI_LOW             2'h0
`define TRI_MID             2'h1
`define TRI_HIGH            2'h2

// ****************************************
// Bus address table
// ****************************************
`define ADDR_LL             8'hd8
`define ADDR_LM             8'hda
`define ADDR_LH             8'hde
`define ADDR_ML             8'hc2
`define ADDR_MM             8'hc4
`define ADDR_MH             8'hc6
`define ADDR_HL             8'hca
`define ADDR_HM             8'hcc
`define ADDR_HH             8'hce

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS       4
`define LOCK_TIME_NS        1800000
`define RESTART_TIME_NS     300000
`define LOCK_CYCLES         (`LOCK_TIME_NS / `CLK_PERIOD_NS)
`define RESTART_CYCLES      (`RESTART_TIME_NS / `CLK_PERIOD_NS)
`define NUM_OUTPUTS         19

`endif

/* File: hdl/clock_buffer_power_mode_ctrl.v */
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "clock_buffer_consts.vh"

module clock_buffer_power_mode_ctrl #(
    parameter LOCK_CYC    = `LOCK_CYCLES,
    parameter RESTART_CYC = `RESTART_CYCLES
) (
    // AHB-Lite clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Pins
    input  wire        ref_clk_in,
    input  wire        power_good_in,
    input  wire        freq_select_strap,
    input  wire [1:0]  addr_strap_low,
    input  wire [1:0]  addr_strap_high,
    input  wire [1:0]  pll_mode_strap,
    // Clock outputs
    output wire [18:0] diff_clock_out_p,
    output wire [18:0] diff_clock_out_n,
    output wire        feedback_out_p,
    output wire        feedback_out_n,
    // Status outputs
    output reg         pll_on,
    output reg         pll_bypass,
    output reg         pll_high_bandwidth,
    output reg         pll_low_bandwidth,
    output reg         freq_is_100,
    output reg  [7:0]  bus_addr,
    output reg         outputs_locked
);

    // ****************************************
    // State codes
    // ****************************************
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_LOCK = 3'h1;
    localparam [2:0] S_RUN  = 3'h2;
    localparam [2:0] S_STOP = 3'h3;
    localparam [2:0] S_OFF  = 3'h4;

    localparam [31:0] LOCK_FULL    = LOCK_CYC - 1;
    localparam [31:0] RESTART_FULL = RESTART_CYC - 1;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire       ref_s;
    wire       pg_s;
    wire       freq_s;
    wire [1:0] sa_low_s;
    wire [1:0] sa_high_s;
    wire [1:0] mode_s;

    sync_two_flop #(
        .W (9)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({ref_clk_in, power_good_in, freq_select_strap,
                    addr_strap_low, addr_strap_high, pll_mode_strap}),
        .sync_out ({ref_s, pg_s, freq_s, sa_low_s, sa_high_s, mode_s})
    );

    // ****************************************
    // Reference edge detection
    // ****************************************
    reg  ref_d_reg;
    wire ref_rise;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_d_reg <= 1'b0;
        end else begin
            ref_d_reg <= ref_s;
        end
    end

    assign ref_rise = ref_s & ~ref_d_reg;

    // ****************************************
    // Registers
    // ****************************************
    reg  [7:0]  oe_low_reg;
    reg  [7:0]  oe_mid_reg;
    reg  [2:0]  oe_high_reg;
    reg  [2:0]  ovr_reg;
    reg  [7:0]  oe_low_next;
    reg  [7:0]  oe_mid_next;
    reg  [2:0]  oe_high_next;
    reg  [2:0]  ovr_next;
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg  [1:0]  latched_mode_reg;
    reg  [1:0]  applied_mode_reg;
    reg         pg_seen_reg;
    reg  [2:0]  state_reg;
    reg  [18:0] count_reg;
    reg         low_seen_reg;
    reg         run_all_reg;
    reg  [31:0] rd_value;
    wire        take;
    wire [18:0] gate_active;
    wire        fb_active;
    wire [1:0]  mode_req;
    wire [18:0] oe_all;

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    // Zero wait states; reads see a write from the cycle before
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign take      = hsel & htrans[1] & hready;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= take & hwrite;
            wr_addr_reg <= haddr;
        end
    end

    always @* begin
        oe_low_next  = oe_low_reg;
        oe_mid_next  = oe_mid_reg;
        oe_high_next = oe_high_reg;
        ovr_next     = ovr_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `CTRL0_ADDR:   oe_high_next = hwdata[`CTRL0_OE_MSB:`CTRL0_OE_LSB];
                `OE_LOW_ADDR:  oe_low_next = hwdata[7:0];
                `OE_MID_ADDR:  oe_mid_next = hwdata[7:0];
                `PLL_OVR_ADDR: ovr_next = hwdata[2:0];
                default:       oe_low_next = oe_low_reg;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_low_reg  <= `OE_LOW_RESET;
            oe_mid_reg  <= `OE_MID_RESET;
            oe_high_reg <= `OE_HIGH_RESET;
            ovr_reg     <= `PLL_OVR_RESET;
        end else begin
            oe_low_reg  <= oe_low_next;
            oe_mid_reg  <= oe_mid_next;
            oe_high_reg <= oe_high_next;
            ovr_reg     <= ovr_next;
        end
    end

    always @* begin
        rd_value = 32'h0000_0000;
        case (haddr)
            `CTRL0_ADDR: begin
                rd_value[`CTRL0_MODE_MSB:`CTRL0_MODE_LSB] = latched_mode_reg;
                rd_value[`CTRL0_OE_MSB:`CTRL0_OE_LSB]     = oe_high_next;
                rd_value[`CTRL0_FREQ_BIT]                 = freq_is_100;
            end
            `OE_LOW_ADDR:  rd_value[7:0] = oe_low_next;
            `OE_MID_ADDR:  rd_value[7:0] = oe_mid_next;
            `PLL_OVR_ADDR: rd_value[2:0] = ovr_next;
            `STATUS_ADDR: begin
                rd_value[15:8] = bus_addr;
                rd_value[6:5]  = applied_mode_reg;
                rd_value[4]    = pll_on;
                rd_value[3]    = outputs_locked;
                rd_value[2]    = ~fb_active;
                rd_value[1]    = ~pg_s;
                rd_value[0]    = pg_seen_reg;
            end
            default:       rd_value = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take & ~hwrite) begin
            hrdata <= rd_value;
        end
    end

    // ****************************************
    // Strap latch
    // ****************************************
    reg [7:0] addr_decode;
    reg [1:0] mode_decode;

    always @* begin
        case ({sa_high_s, sa_low_s})
            {`TRI_LOW,  `TRI_LOW}:  addr_decode = `ADDR_LL;
            {`TRI_LOW,  `TRI_MID}:  addr_decode = `ADDR_LM;
            {`TRI_LOW,  `TRI_HIGH}: addr_decode = `ADDR_LH;
            {`TRI_MID,  `TRI_LOW}:  addr_decode = `ADDR_ML;
            {`TRI_MID,  `TRI_HIGH}: addr_decode = `ADDR_MH;
            {`TRI_HIGH, `TRI_LOW}:  addr_decode = `ADDR_HL;
            {`TRI_HIGH, `TRI_MID}:  addr_decode = `ADDR_HM;
            {`TRI_HIGH, `TRI_HIGH}: addr_decode = `ADDR_HH;
            default:                addr_decode = `ADDR_MM;
        endcase
        case (mode_s)
            `TRI_LOW:  mode_decode = `MODE_LOW_BW;
            `TRI_HIGH: mode_decode = `MODE_HIGH_BW;
            default:   mode_decode = `MODE_BYPASS;
        endcase
    end

    // Straps caught once, on the first power-good after reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pg_seen_reg      <= 1'b0;
            freq_is_100      <= 1'b0;
            bus_addr         <= `ADDR_MM;
            latched_mode_reg <= `MODE_BYPASS;
        end else if (pg_s & ~pg_seen_reg) begin
            pg_seen_reg      <= 1'b1;
            freq_is_100      <= freq_s;
            bus_addr         <= addr_decode;
            latched_mode_reg <= mode_decode;
        end
    end

    // Override only counts with its enable bit set
    assign mode_req = ovr_reg[`OVR_ENABLE_BIT] ? ovr_reg[1:0] : latched_mode_reg;

    // ****************************************
    // Power sequencing
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg        <= S_IDLE;
            count_reg        <= 19'h00000;
            low_seen_reg     <= 1'b0;
            run_all_reg      <= 1'b0;
            pll_on           <= 1'b0;
            outputs_locked   <= 1'b0;
            applied_mode_reg <= `MODE_BYPASS;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (pg_s) begin
                        pll_on           <= 1'b1;
                        applied_mode_reg <= mode_decode;
                        count_reg        <= LOCK_FULL[18:0];
                        state_reg        <= S_LOCK;
                    end
                end
                S_LOCK: begin
                    if (!pg_s) begin
                        pll_on    <= 1'b0;
                        state_reg <= S_OFF;
                    end else if (count_reg == 19'h00000 || applied_mode_reg == `MODE_BYPASS) begin
                        outputs_locked <= 1'b1;
                        run_all_reg    <= 1'b1;
                        low_seen_reg   <= 1'b0;
                        state_reg      <= S_RUN;
                    end else begin
                        count_reg <= count_reg - 19'h00001;
                    end
                end
                S_RUN: begin
                    if (ref_rise) begin
                        low_seen_reg <= ~pg_s;
                        if (!pg_s && low_seen_reg) begin
                            run_all_reg <= 1'b0;
                            state_reg   <= S_STOP;
                        end
                    end
                end
                S_STOP: begin
                    // Oscillator kept alive until every pair is Low/Low
                    if (~|gate_active && !fb_active) begin
                        pll_on         <= 1'b0;
                        outputs_locked <= 1'b0;
                        state_reg      <= S_OFF;
                    end
                end
                S_OFF: begin
                    if (pg_s) begin
                        pll_on           <= 1'b1;
                        applied_mode_reg <= mode_req;
                        count_reg        <= RESTART_FULL[18:0];
                        state_reg        <= S_LOCK;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_bypass         <= 1'b0;
            pll_high_bandwidth <= 1'b0;
            pll_low_bandwidth  <= 1'b0;
        end else begin
            pll_bypass         <= pll_on & (applied_mode_reg == `MODE_BYPASS);
            pll_high_bandwidth <= pll_on & (applied_mode_reg == `MODE_HIGH_BW);
            pll_low_bandwidth  <= pll_on & (applied_mode_reg == `MODE_LOW_BW);
        end
    end

    // ****************************************
    // Output gating
    // ****************************************
    // Pairs follow the sampled reference one to one; no divider exists
    assign oe_all = {oe_high_reg, oe_mid_reg, oe_low_reg};

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_OUTPUTS; gi = gi + 1) begin : g_out
            diff_out_gate u_gate (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .clk_level (ref_s),
                .run       (run_all_reg & oe_all[gi]),
                .out_p     (diff_clock_out_p[gi]),
                .out_n     (diff_clock_out_n[gi]),
                .active    (gate_active[gi])
            );
        end
    endgenerate

    diff_out_gate u_fb_gate (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_level (ref_s),
        .run       (run_all_reg),
        .out_p     (feedback_out_p),
        .out_n     (feedback_out_n),
        .active    (fb_active)
    );

endmodule

/* File: hdl/diff_out_gate.v */
`timescale 1ns/1ps

module diff_out_gate (
    // Clock and reset
    input  wire hclk,
    input  wire hresetn,
    // Control
    input  wire clk_level,
    input  wire run,
    // Pair
    output reg  out_p,
    output reg  out_n,
    output reg  active
);

    // Enable only moves while the clock is low, so out_p gets no runt pulse; out_n can still get a short one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active <= 1'b0;
            out_p  <= 1'b0;
            out_n  <= 1'b0;
        end else begin
            if (!clk_level) begin
                active <= run;
            end
            out_p <= active & clk_level;
            out_n <= active & ~clk_level;
        end
    end

endmodule

/* File: hdl/sync_two_flop.v */
`timescale 1ns/1ps

module sync_two_flop #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    // Data
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* File: verif/clock_buffer_power_mode_ctrl_tb.sv */
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module clock_buffer_power_mode_ctrl_tb;
    localparam int         LOCK         = 20;
    localparam int         RESTART      = 10;
    localparam logic [7:0] ADDR_TAB [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
    localparam logic [2:0] MODE_TAB [3] = '{3'b001, 3'b100, 3'b010};
    localparam logic [1:0] READ_TAB [3] = '{2'h0, 2'h1, 2'h3};
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pg_req = 1'b0, freq_select_strap = 1'b0;
    logic [1:0]  htrans = 2'h0, addr_strap_low = 2'h0, addr_strap_high = 2'h0, pll_mode_strap = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, rd;
    wire  [31:0] hrdata;
    wire  [18:0] diff_clock_out_p, diff_clock_out_n;
    wire  [7:0]  bus_addr;
    wire         hreadyout, hresp, ref_clk_in, power_good_in, feedback_out_p, feedback_out_n, pll_on, pll_bypass;
    wire         pll_high_bandwidth, pll_low_bandwidth, freq_is_100, outputs_locked;
    int          mismatches = 0, checked = 0, n;

    always #2 hclk = ~hclk;

    clock_buffer_power_mode_ctrl #(.LOCK_CYC(LOCK), .RESTART_CYC(RESTART)) clock_buffer_power_mode_ctrl_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .ref_clk_in, .power_good_in, .freq_select_strap, .addr_strap_low, .addr_strap_high,
        .pll_mode_strap, .diff_clock_out_p, .diff_clock_out_n, .feedback_out_p, .feedback_out_n, .pll_on,
        .pll_bypass, .pll_high_bandwidth, .pll_low_bandwidth, .freq_is_100, .bus_addr, .outputs_locked);
    ref_clock_source ref_clock_source_inst (.hclk, .pg_req, .ref_clk_in, .power_good_in);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wait_locked();
        n = 0;
        while (outputs_locked !== 1'b1 && n < 1000) begin
            @(posedge hclk);
            n++;
        end
    endtask

    // Long gap lets the board stop the reference while powered down
    task automatic power_cycle();
        pg_req <= 1'b0;
        n = 0;
        while (pll_on !== 1'b0 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        check(n < 64, 1'b1, "stop latency");
        repeat (4) @(posedge hclk);
        check(|{diff_clock_out_p, diff_clock_out_n, feedback_out_p, feedback_out_n}, 1'b0, "outputs off");
        repeat (120) @(posedge hclk);
        pg_req <= 1'b1;
        @(posedge hclk);
        wait_locked();
        check(n <= RESTART + 16, 1'b1, "restart latency");
    endtask

    task automatic boot(input int hi, input int lo, input int md, input logic f);
        pg_req            <= 1'b0;
        hresetn           <= 1'b0;
        addr_strap_high   <= 2'(hi);
        addr_strap_low    <= 2'(lo);
        pll_mode_strap    <= 2'(md);
        freq_select_strap <= f;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        pg_req <= 1'b1;
        @(posedge hclk);
        wait_locked();
    endtask

    task automatic test_reset_regs();
        ahb(1'b0, 8'h00, 32'h0);
        check(rd & 32'h38, 32'h38, "ctrl0 enables");
        ahb(1'b0, 8'h04, 32'h0);
        check(rd, 32'hff, "enables low");
        ahb(1'b0, 8'h08, 32'h0);
        check(rd, 32'hff, "enables mid");
        ahb(1'b0, 8'h48, 32'h0);
        check(rd, 32'h0, "override");
        ahb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0, "unmapped");
        check(hresp, 1'b0, "response");
        check(hreadyout, 1'b1, "ready");
        $display("test_reset_regs done");
    endtask

    task automatic test_strap_table();
        for (int i = 0; i < 9; i++) begin
            boot(i / 3, i % 3, i % 3, i[0]);
            check(n <= LOCK + 16, 1'b1, "lock latency");
            check(bus_addr, ADDR_TAB[i], "bus address");
            check(freq_is_100, i[0], "frequency");
            check({pll_bypass, pll_high_bandwidth, pll_low_bandwidth}, MODE_TAB[i % 3], "mode");
            ahb(1'b0, 8'h00, 32'h0);
            check(rd[7:6], READ_TAB[i % 3], "mode readback");
            check(rd[0], i[0], "frequency readback");
        end
        $display("test_strap_table done");
    endtask

    task automatic test_latch_hold();
        addr_strap_low    <= 2'h0;
        addr_strap_high   <= 2'h1;
        pll_mode_strap    <= 2'h1;
        freq_select_strap <= 1'b1;
        power_cycle();
        check(bus_addr, 8'hce, "address kept");
        check(freq_is_100, 1'b0, "frequency kept");
        check(pll_high_bandwidth, 1'b1, "mode kept");
        $display("test_latch_hold done");
    endtask

    task automatic test_enable();
        logic p1, pf;
        int   r1, rf, stuck;
        ahb(1'b1, 8'h04, 32'hfe);
        ahb(1'b1, 8'h00, 32'h0);
        ahb(1'b0, 8'h00, 32'h0);
        check(rd & 32'h38, 32'h0, "enables cleared");
        repeat (20) @(posedge hclk);
        p1 = diff_clock_out_p[1];
        pf = feedback_out_p;
        r1 = 0;
        rf = 0;
        stuck = 0;
        repeat (60) begin
            @(posedge hclk);
            r1 += (diff_clock_out_p[1] && !p1);
            rf += (feedback_out_p && !pf);
            stuck += (diff_clock_out_p[0] | diff_clock_out_n[0] | diff_clock_out_p[16] | diff_clock_out_n[16]);
            p1 = diff_clock_out_p[1];
            pf = feedback_out_p;
        end
        check(r1, 6, "output edges");
        check(rf, 6, "feedback edges");
        check(stuck, 0, "disabled outputs");
        ahb(1'b1, 8'h04, 32'hff);
        ahb(1'b1, 8'h00, 32'h38);
        $display("test_enable done");
    endtask

    task automatic test_override();
        ahb(1'b1, 8'h48, 32'h5);
        ahb(1'b0, 8'h48, 32'h0);
        check(rd & 32'h7, 32'h5, "override readback");
        check(pll_high_bandwidth, 1'b1, "mode before restart");
        power_cycle();
        check(pll_bypass, 1'b1, "overridden mode");
        ahb(1'b0, 8'h00, 32'h0);
        check(rd[7:6], 2'h3, "latched readback");
        ahb(1'b1, 8'h48, 32'h1);
        power_cycle();
        check(pll_high_bandwidth, 1'b1, "override off");
        $display("test_override done");
    endtask

    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset_regs();
        test_strap_table();
        test_latch_hold();
        test_enable();
        test_override();
        complete_run();
    end

    // Whole run needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        complete_run();
    end
endmodule

/* File: verif/clock_buffer_props.sv */
`timescale 1ns/1ps
// ****************************************
// Power and mode checks
// ****************************************
module clock_buffer_props #(
    parameter int LOCK_CYC    = 450000,
    parameter int RESTART_CYC = 75000
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Pins
    input wire logic        power_good_in,
    input wire logic        freq_select_strap,
    input wire logic [1:0]  addr_strap_low,
    input wire logic [1:0]  addr_strap_high,
    input wire logic [1:0]  pll_mode_strap,
    // Outputs
    input wire logic [18:0] diff_clock_out_p,
    input wire logic [18:0] diff_clock_out_n,
    input wire logic        feedback_out_p,
    input wire logic        feedback_out_n,
    input wire logic        pll_on,
    input wire logic        pll_bypass,
    input wire logic        pll_high_bandwidth,
    input wire logic        pll_low_bandwidth,
    input wire logic        freq_is_100,
    input wire logic [7:0]  bus_addr,
    input wire logic        outputs_locked
);
    localparam logic [7:0] ADDR_TAB [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
    localparam logic [2:0] MODE_TAB [3] = '{3'b001, 3'b100, 3'b010};
    logic [31:0] wait_cnt;
    logic        seen_lock;
    wire  [2:0]  mode_now;
    wire         addr_ok;
    wire         mode_ok;

    function automatic int tri_level(input logic [1:0] s);
        return (s == 2'h0) ? 0 : ((s == 2'h2) ? 2 : 1);
    endfunction

    assign mode_now = {pll_bypass, pll_high_bandwidth, pll_low_bandwidth};
    assign addr_ok  = (bus_addr == ADDR_TAB[tri_level(addr_strap_high) * 3 + tri_level(addr_strap_low)]);
    assign mode_ok  = (mode_now == MODE_TAB[tri_level(pll_mode_strap)]);

    // Counted from pll_on, so one counter bounds both boot and relock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt  <= 32'h0;
            seen_lock <= 1'b0;
        end else begin
            wait_cnt  <= (pll_on && !outputs_locked) ? wait_cnt + 32'h1 : 32'h0;
            seen_lock <= seen_lock | outputs_locked;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence first_up;
        $rose(pll_on) && !seen_lock;
    endsequence
    sequence pll_off_held;
        !pll_on [*4];
    endsequence
    sequence pd_seen;
        $fell(power_good_in) && outputs_locked;
    endsequence

    strap_latch_a: assert property (first_up |-> ##2 (addr_ok && freq_is_100 == freq_select_strap))
        else $error("straps not latched at power-good");
    addr_hold_a: assert property (seen_lock |-> $stable(bus_addr) && $stable(freq_is_100))
        else $error("latched straps changed after lock");
    mode_pick_a: assert property (outputs_locked |-> $onehot(mode_now) && (seen_lock || mode_ok))
        else $error("pll mode does not match strap");
    pd_stop_a: assert property (pd_seen |-> ##[1:64] !pll_on)
        else $error("power-down not taken in time");
    off_quiet_a: assert property (pll_off_held |-> !(|{diff_clock_out_p, diff_clock_out_n, feedback_out_p, feedback_out_n}))
        else $error("outputs not low while pll off");
    no_runt_a: assert property ($rose(feedback_out_p) |-> feedback_out_p [*3])
        else $error("short high pulse on feedback");
    lock_time_a: assert property (!seen_lock |-> wait_cnt <= LOCK_CYC + 16)
        else $error("lock took too long");
    restart_time_a: assert property (seen_lock |-> wait_cnt <= RESTART_CYC + 16)
        else $error("restart took too long");
endmodule

bind clock_buffer_power_mode_ctrl clock_buffer_props #(.LOCK_CYC(LOCK_CYC), .RESTART_CYC(RESTART_CYC)) props_inst (
    .hclk, .hresetn, .power_good_in, .freq_select_strap, .addr_strap_low, .addr_strap_high, .pll_mode_strap,
    .diff_clock_out_p, .diff_clock_out_n, .feedback_out_p, .feedback_out_n, .pll_on, .pll_bypass,
    .pll_high_bandwidth, .pll_low_bandwidth, .freq_is_100, .bus_addr, .outputs_locked);

/* File: verif/ref_clock_source.sv */
`timescale 1ns/1ps
// ****************************************
// Board side: reference clock and power-good
// ****************************************
module ref_clock_source #(
    parameter int HALF = 5
) (
    // Clock
    input  wire logic hclk,
    // Board sequencing
    input  wire logic pg_req,
    // Pins
    output wire logic ref_clk_in,
    output wire logic power_good_in
);
    logic ref_q    = 1'b0;
    logic pg_q     = 1'b0;
    int   half_cnt = 0;
    int   low_cnt  = 0;

    assign ref_clk_in    = ref_q;
    assign power_good_in = pg_q;

    // Reference runs one to one with the outputs and stops only
    // a long while after power-down, never ahead of it
    always @(posedge hclk) begin
        pg_q    <= pg_req;
        low_cnt <= pg_q ? 0 : ((low_cnt < 100) ? low_cnt + 1 : low_cnt);
        if (pg_q || low_cnt < 100) begin
            half_cnt <= (half_cnt == HALF - 1) ? 0 : half_cnt + 1;
            ref_q    <= (half_cnt == HALF - 1) ? ~ref_q : ref_q;
        end else begin
            ref_q <= 1'b0;
        end
    end
endmodule
